// ===== verilog/ltc_pkg.sv
// Constants, field layouts and carrier types of the LCD panel timing core
package ltc_pkg;
    // Register byte addresses
    localparam logic [31:0] TIMING_CFG_ADDR = 32'h01F00000;
    localparam logic [31:0] GEOMETRY_CFG_ADDR = 32'h01F00004;
    localparam logic [31:0] BIAS_RATE_ADDR = 32'h01F0000C;
    // Reset values
    localparam logic [31:0] TIMING_CFG_RESET = 32'h00000000;
    localparam logic [31:0] GEOMETRY_CFG_RESET = 32'h00000000;
    localparam logic [7:0] BIAS_RATE_RESET = 8'h00;
    // Field positions
    localparam int LINE_CNT_LSB = 22;
    localparam int LINE_CNT_W = 10;
    localparam int TIMING_W = 22;
    localparam int BIAS_RATE_LSB = 21;
    localparam int BIAS_RATE_W = 8;
    localparam int DIV_W = 10;
    localparam int BLANK_W = 11;
    localparam int HSIZE_W = 11;
    // Line pulse width and delay advance in steps of this many clocks
    localparam int STEP_CLOCKS = 4;

    typedef enum logic [1:0] {
        FMT_DUAL4,
        FMT_SINGLE4,
        FMT_SINGLE8,
        FMT_UNUSED
    } ltc_format_t;

    // Writable part of the timing register, bits [21:0]
    typedef struct packed {
        logic [9:0] pixelClockDivider;
        logic [1:0] linePulseWidth;
        logic [1:0] lineToClockDelay;
        logic biasMode;
        ltc_format_t panelBusFormat;
        logic pixelClockPolarity;
        logic linePulsePolarity;
        logic framePulsePolarity;
        logic dataPolarity;
        logic videoEnable;
    } ltc_timing_t;

    typedef struct packed {
        logic [10:0] lineBlankA;
        logic [10:0] horizontalSize;
        logic [9:0] verticalSize;
    } ltc_geometry_t;

    typedef struct packed {
        logic pixelShiftClock;
        logic linePulse;
        logic framePulse;
        logic acBiasOutput;
        logic [7:0] videoDataPins;
    } ltc_pins_t;
endpackage

// ===== verilog/ltc_span_counter.sv
// Loadable down counter that marks the last cycle of a timed span
module ltc_span_counter import ltc_pkg::*; #(
    parameter int W = 11
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [W-1:0] loadValue,
    output logic lastCycle
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    always_comb begin
        count_nxt = count_r;
        if (load) begin
            count_nxt = loadValue;
        end else if (count_r != '0) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // A span of N cycles ends in the cycle where one remains
    assign lastCycle = (count_r == W'(1));
endmodule

// ===== verilog/ltc_pixel_divider.sv
// Divides the system clock into the raw pixel shift clock
module ltc_pixel_divider import ltc_pkg::*; #(
    parameter int W = DIV_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [W-1:0] divider,
    output logic pixelClock,
    output logic riseStb,
    output logic fallStb
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic level_r;
    logic level_nxt;
    logic [W-1:0] halfPeriod;

    // Zero would stall the clock, so it behaves as one
    assign halfPeriod = (divider == '0) ? W'(1) : divider;

    always_comb begin
        count_nxt = count_r;
        level_nxt = level_r;
        riseStb = 1'b0;
        fallStb = 1'b0;
        if (!run) begin
            count_nxt = '0;
            level_nxt = 1'b0;
        end else if (count_r == halfPeriod - 1'b1) begin
            count_nxt = '0;
            level_nxt = !level_r;
            riseStb = !level_r;
            fallStb = level_r;
        end else begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            count_r <= '0;
            level_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            level_r <= level_nxt;
        end
    end

    assign pixelClock = level_r;
endmodule

// ===== verilog/ltc_timing_core.sv
// LCD panel timing core: registers, line sequencer, frame and bias logic
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Read-only line counter counts down per line, reloads per frame
// - Pixel clock is system clock over twice divider
// - Divider change while enabled waits for frame end
// - Line pulse width 4, 8, 12, 16 clocks
// - Line-to-clock delay 4, 8, 12, 16 clocks
// - Bias toggles per frame, or at bias rate
// - Bus format: dual4, single4, single8, unused
// - Clock polarity picks panel sampling edge
// - Line pulse polarity normal or inverted
// - Frame pulse polarity normal or inverted
// - Data polarity inverts all eight data pins
// - Enable runs logic; disable stops, clears FIFO
// - Line blank withholds pixel clock per line
// - Vertical size sets lines per frame
// - Eight-bit bias rate field sets toggle rate
//
// Strobed register access was left to the implementer.
module ltc_timing_core import ltc_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData,
    input wire logic [7:0] videoByte,
    output logic videoByteTaken,
    output logic fifoClear,
    output ltc_pins_t panelPins
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PULSE,
        ST_DELAY,
        ST_SHIFT,
        ST_BLANK
    } ltc_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    ltc_timing_t timing_r;
    ltc_timing_t timing_nxt;
    ltc_geometry_t geometry_r;
    ltc_geometry_t geometry_nxt;
    logic [BIAS_RATE_W-1:0] biasRate_r;
    logic [BIAS_RATE_W-1:0] biasRate_nxt;
    logic [31:0] rdData_r;
    logic [31:0] rdData_nxt;
    logic [LINE_CNT_W-1:0] lineCounter_r;

    always_comb begin
        timing_nxt = timing_r;
        geometry_nxt = geometry_r;
        biasRate_nxt = biasRate_r;
        rdData_nxt = 32'h00000000;
        if (regWrStb) begin
            unique case (regAddr)
                TIMING_CFG_ADDR: timing_nxt = regWrData[TIMING_W-1:0];
                GEOMETRY_CFG_ADDR: geometry_nxt = regWrData;
                BIAS_RATE_ADDR: biasRate_nxt = regWrData[BIAS_RATE_LSB +: BIAS_RATE_W];
                default: ;
            endcase
        end
        if (regRdStb) begin
            unique case (regAddr)
                TIMING_CFG_ADDR: rdData_nxt = {lineCounter_r, timing_r};
                GEOMETRY_CFG_ADDR: rdData_nxt = geometry_r;
                BIAS_RATE_ADDR: rdData_nxt = {3'h0, biasRate_r, 21'h0};
                default: rdData_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            timing_r <= TIMING_CFG_RESET[TIMING_W-1:0];
            geometry_r <= GEOMETRY_CFG_RESET;
            biasRate_r <= BIAS_RATE_RESET;
            rdData_r <= 32'h00000000;
        end else begin
            timing_r <= timing_nxt;
            geometry_r <= geometry_nxt;
            biasRate_r <= biasRate_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;

    ////////////////////////////////////////////////////////////////////////////
    // Line sequencer
    ltc_state_t state_r;
    ltc_state_t state_nxt;
    logic [DIV_W-1:0] activeDiv_r;
    logic [DIV_W-1:0] activeDiv_nxt;
    logic [LINE_CNT_W-1:0] lineCounter_nxt;
    logic [HSIZE_W:0] pixRemain_r;
    logic [HSIZE_W:0] pixRemain_nxt;
    logic frameStart_r;
    logic frameStart_nxt;
    logic acBias_r;
    logic acBias_nxt;
    logic [BIAS_RATE_W-1:0] biasCount_r;
    logic [BIAS_RATE_W-1:0] biasCount_nxt;
    logic [7:0] shiftData_r;
    logic [7:0] shiftData_nxt;
    logic spanLoad;
    logic [BLANK_W-1:0] spanValue;
    logic spanLast;
    logic pixRaw;
    logic pixRise;
    logic pixFall;
    logic lineEnd;
    logic frameEnd;
    logic enable;

    assign enable = timing_r.videoEnable;

    // Steps of four clocks: code 0 gives 4, code 3 gives 16
    function automatic logic [BLANK_W-1:0] step_clocks(input logic [1:0] code);
        step_clocks = BLANK_W'((int'(code) + 1) * STEP_CLOCKS);
    endfunction

    always_comb begin
        state_nxt = state_r;
        lineEnd = 1'b0;
        if (!enable) begin
            state_nxt = ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: state_nxt = ST_PULSE;
                ST_PULSE: if (spanLast) state_nxt = ST_DELAY;
                ST_DELAY: if (spanLast) state_nxt = ST_SHIFT;
                ST_SHIFT: begin
                    if (pixFall && pixRemain_r == (HSIZE_W + 1)'(1)) begin
                        if (geometry_r.lineBlankA != '0) begin
                            state_nxt = ST_BLANK;
                        end else begin
                            state_nxt = ST_PULSE;
                            lineEnd = 1'b1;
                        end
                    end
                end
                ST_BLANK: begin
                    if (spanLast) begin
                        state_nxt = ST_PULSE;
                        lineEnd = 1'b1;
                    end
                end
            endcase
        end
    end

    // Span counter loads as each timed state is entered
    always_comb begin
        spanLoad = (state_nxt != state_r);
        unique case (state_nxt)
            ST_PULSE: spanValue = step_clocks(timing_r.linePulseWidth);
            ST_DELAY: spanValue = step_clocks(timing_r.lineToClockDelay);
            ST_BLANK: spanValue = geometry_r.lineBlankA;
            default: spanValue = '0;
        endcase
    end

    ltc_span_counter #(
        .W(BLANK_W)
    ) u_span (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .load(spanLoad),
        .loadValue(spanValue),
        .lastCycle(spanLast)
    );

    // Clock runs only while shifting, so blank and delay withhold it
    ltc_pixel_divider #(
        .W(DIV_W)
    ) u_divider (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .run(state_r == ST_SHIFT),
        .divider(activeDiv_r),
        .pixelClock(pixRaw),
        .riseStb(pixRise),
        .fallStb(pixFall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Line, frame and bias bookkeeping
    assign frameEnd = lineEnd && (lineCounter_r == '0);

    always_comb begin
        lineCounter_nxt = lineCounter_r;
        frameStart_nxt = frameStart_r;
        activeDiv_nxt = activeDiv_r;
        pixRemain_nxt = pixRemain_r;
        acBias_nxt = acBias_r;
        biasCount_nxt = biasCount_r;
        shiftData_nxt = shiftData_r;
        if (!enable) begin
            // Idle core follows the register so the first frame uses it
            activeDiv_nxt = timing_r.pixelClockDivider;
            lineCounter_nxt = geometry_r.verticalSize;
            frameStart_nxt = 1'b1;
            biasCount_nxt = '0;
            shiftData_nxt = 8'h00;
        end else begin
            if (state_nxt == ST_SHIFT && state_r != ST_SHIFT) begin
                pixRemain_nxt = {1'b0, geometry_r.horizontalSize} + 1'b1;
            end else if (pixFall) begin
                pixRemain_nxt = pixRemain_r - 1'b1;
            end
            if (pixRise) begin
                shiftData_nxt = videoByte;
            end
            if (state_r == ST_PULSE && spanLast) begin
                frameStart_nxt = 1'b0;
            end
            if (lineEnd) begin
                if (frameEnd) begin
                    lineCounter_nxt = geometry_r.verticalSize;
                    frameStart_nxt = 1'b1;
                    activeDiv_nxt = timing_r.pixelClockDivider;
                end else begin
                    lineCounter_nxt = lineCounter_r - 1'b1;
                end
                if (timing_r.biasMode) begin
                    if (biasCount_r >= biasRate_r) begin
                        biasCount_nxt = '0;
                        acBias_nxt = !acBias_r;
                    end else begin
                        biasCount_nxt = biasCount_r + 1'b1;
                    end
                end else if (frameEnd) begin
                    acBias_nxt = !acBias_r;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            lineCounter_r <= '0;
            frameStart_r <= 1'b0;
            activeDiv_r <= '0;
            pixRemain_r <= '0;
            acBias_r <= 1'b0;
            biasCount_r <= '0;
            shiftData_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            lineCounter_r <= lineCounter_nxt;
            frameStart_r <= frameStart_nxt;
            activeDiv_r <= activeDiv_nxt;
            pixRemain_r <= pixRemain_nxt;
            acBias_r <= acBias_nxt;
            biasCount_r <= biasCount_nxt;
            shiftData_r <= shiftData_nxt;
        end
    end

    // Byte is consumed at the edge where the panel is not sampling
    assign videoByteTaken = pixRise;
    assign fifoClear = !enable;

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers
    ltc_pins_t pins_r;
    ltc_pins_t pins_nxt;
    logic [7:0] busData;

    // Format decides which data lines carry live nibbles
    always_comb begin
        unique case (timing_r.panelBusFormat)
            FMT_DUAL4: busData = shiftData_r;
            FMT_SINGLE4: busData = {4'h0, shiftData_r[3:0]};
            FMT_SINGLE8: busData = shiftData_r;
            FMT_UNUSED: busData = 8'h00;
        endcase
    end

    always_comb begin
        pins_nxt.pixelShiftClock = pixRaw ^ timing_r.pixelClockPolarity;
        pins_nxt.linePulse = (state_r == ST_PULSE) ^ timing_r.linePulsePolarity;
        pins_nxt.framePulse = (state_r == ST_PULSE && frameStart_r)
            ^ timing_r.framePulsePolarity;
        pins_nxt.acBiasOutput = acBias_r;
        pins_nxt.videoDataPins = busData ^ {8{timing_r.dataPolarity}};
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pins_r <= '0;
        end else begin
            pins_r <= pins_nxt;
        end
    end

    assign panelPins = pins_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_line_counter_wraps;
        @(posedge ref_clk) disable iff (!reset_n)
        frameEnd |=> lineCounter_r == $past(geometry_r.verticalSize);
    endproperty
    a_line_counter_wraps: assert property (p_line_counter_wraps) else
        $error("line counter not reloaded at frame end");

    property p_line_counter_steps;
        @(posedge ref_clk) disable iff (!reset_n)
        (lineEnd && !frameEnd) |=> lineCounter_r == $past(lineCounter_r) - 1'b1;
    endproperty
    a_line_counter_steps: assert property (p_line_counter_steps) else
        $error("line counter did not count down");

    property p_divider_held;
        @(posedge ref_clk) disable iff (!reset_n)
        (enable && !frameEnd) |=> $stable(activeDiv_r);
    endproperty
    a_divider_held: assert property (p_divider_held) else
        $error("divider changed inside a frame");

    // Disabling cuts a span short, so spans are only timed while enabled
    property p_pulse_width_min;
        @(posedge ref_clk) disable iff (!reset_n || !enable)
        (enable && state_r == ST_PULSE && timing_r.linePulseWidth == 2'h0
            && $past(state_r) != ST_PULSE) |-> (state_r == ST_PULSE) [*4]
            ##1 (state_r != ST_PULSE);
    endproperty
    a_pulse_width_min: assert property (p_pulse_width_min) else
        $error("line pulse width wrong");

    property p_delay_len;
        @(posedge ref_clk) disable iff (!reset_n || !enable)
        (enable && state_r == ST_DELAY && timing_r.lineToClockDelay == 2'h1
            && $past(state_r) != ST_DELAY) |-> (state_r == ST_DELAY) [*8]
            ##1 (state_r != ST_DELAY);
    endproperty
    a_delay_len: assert property (p_delay_len) else
        $error("line to clock delay wrong");

    property p_clock_withheld;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r != ST_SHIFT && $past(state_r) != ST_SHIFT)
            |=> panelPins.pixelShiftClock == $past(timing_r.pixelClockPolarity);
    endproperty
    a_clock_withheld: assert property (p_clock_withheld) else
        $error("pixel clock ran outside shifting");

    property p_data_polarity;
        @(posedge ref_clk) disable iff (!reset_n)
        timing_r.panelBusFormat == FMT_SINGLE8 |=> panelPins.videoDataPins
            == ($past(shiftData_r) ^ {8{$past(timing_r.dataPolarity)}});
    endproperty
    a_data_polarity: assert property (p_data_polarity) else
        $error("video data polarity wrong");

    property p_disable_idles;
        @(posedge ref_clk) disable iff (!reset_n)
        !enable |=> state_r == ST_IDLE && shiftData_r == 8'h00;
    endproperty
    a_disable_idles: assert property (p_disable_idles) else
        $error("core kept running while disabled");

    property p_bias_frame;
        @(posedge ref_clk) disable iff (!reset_n)
        (enable && !timing_r.biasMode && lineEnd) |=> (acBias_r != $past(acBias_r)) == $past(frameEnd);
    endproperty
    a_bias_frame: assert property (p_bias_frame) else
        $error("bias did not follow frame");
endmodule

// ===== dv/ltc_panel_model.sv
// Behavioural passive panel: samples data and measures line, frame and bias timing
module ltc_panel_model import ltc_pkg::*; (
    input wire logic ref_clk,
    input wire ltc_pins_t pins,
    input wire logic clkPol,
    input wire logic linePol,
    input wire logic framePol,
    output logic sampleStb,
    output logic [7:0] sampleByte,
    output logic lineStb,
    output logic frameStb,
    output logic biasStb,
    output int pulseW,
    output int delayC,
    output int pixCnt,
    output int periodC,
    output int lineC,
    output int frameLines,
    output int biasLines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic raw;
    logic line;
    logic rawPrev = 1'b0;
    logic linePrev = 1'b0;
    logic biasPrev = 1'b0;
    logic inFrame = 1'b0;
    int w = 0;
    int dly = 0;
    int pc = 0;
    int per = 0;
    int lc = 0;
    int fl = 0;
    int bl = 0;
    int firstRise = 0;
    assign raw = pins.pixelShiftClock ^ clkPol;
    assign line = pins.linePulse ^ linePol;
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        sampleStb <= 1'b0;
        lineStb <= 1'b0;
        frameStb <= 1'b0;
        biasStb <= 1'b0;
        lc++;
        if (line && !linePrev) begin
            lineStb <= 1'b1;
            {pulseW, delayC, pixCnt, periodC, lineC} <= {w, dly, pc, per, lc};
            {w, dly, pc, per, lc} = '0;
            fl++;
            bl++;
        end
        if (line) w++;
        if (line && (pins.framePulse ^ framePol)) inFrame = 1'b1;
        if (!line && linePrev && inFrame) begin
            frameStb <= 1'b1;
            frameLines <= fl;
            fl = 0;
            inFrame = 1'b0;
        end
        if (raw && !rawPrev) begin
            pc++;
            if (pc == 1) firstRise = lc;
            if (pc == 2) per = lc - firstRise;
        end
        if (!line && pc == 0) dly++;
        // Panel latches on the raw falling edge, whatever the pin polarity
        if (!raw && rawPrev) begin
            sampleStb <= 1'b1;
            sampleByte <= pins.videoDataPins;
        end
        if (pins.acBiasOutput != biasPrev) begin
            biasStb <= 1'b1;
            biasLines <= bl;
            bl = 0;
        end
        {rawPrev, linePrev, biasPrev} = {raw, line, pins.acBiasOutput};
    end
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the LCD panel timing core
module tb_top import ltc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset_n;
    logic [31:0] regAddr, regWrData, regRdData;
    logic regWrStb, regRdStb, videoByteTaken, fifoClear;
    logic [7:0] videoByte, sampleByte;
    ltc_pins_t panelPins;
    logic sampleStb, lineStb, frameStb, biasStb, rdSeen;
    int pulseW, delayC, pixCnt, periodC, lineC, frameLines, biasLines;
    int errors = 0, samples_checked = 0, cycles = 0;
    ltc_timing_t tcfg = '0;
    ltc_geometry_t gcfg = '0;
    logic [7:0] brate = '0;
    int expDiv, pendDiv;
    bit live = 0, newByte = 0, lineSkip, frameSkip, biasSkip;
    logic [31:0] rdQ[$];
    logic [7:0] dataQ[$];

    ltc_timing_core dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .videoByte(videoByte), .videoByteTaken(videoByteTaken), .fifoClear(fifoClear),
        .panelPins(panelPins));
    ltc_panel_model panel_u (.ref_clk(ref_clk), .pins(panelPins),
        .clkPol(tcfg.pixelClockPolarity), .linePol(tcfg.linePulsePolarity),
        .framePol(tcfg.framePulsePolarity), .sampleStb(sampleStb), .sampleByte(sampleByte),
        .lineStb(lineStb), .frameStb(frameStb), .biasStb(biasStb), .pulseW(pulseW),
        .delayC(delayC), .pixCnt(pixCnt), .periodC(periodC), .lineC(lineC),
        .frameLines(frameLines), .biasLines(biasLines));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge ref_clk);
        regWrStb <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        rdQ.push_back(exp);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge ref_clk);
        regRdStb <= 1'b0;
    endtask

    function automatic logic [7:0] fmt_byte(input logic [7:0] b);
        case (tcfg.panelBusFormat)
            FMT_SINGLE4: fmt_byte = {4'h0, b[3:0]};
            FMT_UNUSED: fmt_byte = 8'h00;
            default: fmt_byte = b;
        endcase
        fmt_byte = fmt_byte ^ {8{tcfg.dataPolarity}};
    endfunction

    // Each format, random timing; a nonzero newDiv rewrites the divider mid-frame
    task automatic run_cfg(input int f, input int newDiv);
        tcfg = ltc_timing_t'(22'($urandom));
        tcfg.pixelClockDivider = 10'($urandom_range(3, 1));
        tcfg.panelBusFormat = ltc_format_t'(f);
        tcfg.biasMode = f[0];
        tcfg.pixelClockPolarity = f[1];
        // Every pin polarity takes both values over the four formats
        {tcfg.linePulsePolarity, tcfg.framePulsePolarity, tcfg.dataPolarity} = 3'(f * 3);
        if (f == 0) begin
            tcfg.linePulseWidth = 2'h0;
            tcfg.lineToClockDelay = 2'h1;
        end
        tcfg.videoEnable = 1'b0;
        gcfg = {11'($urandom_range(7)), 11'h003, 10'h002};
        brate = 8'($urandom_range(3));
        wr(GEOMETRY_CFG_ADDR, gcfg);
        wr(BIAS_RATE_ADDR, {3'h0, brate, 21'h0});
        wr(TIMING_CFG_ADDR, {10'h3FF, tcfg});
        rd(TIMING_CFG_ADDR, {gcfg.verticalSize, tcfg});
        rd(GEOMETRY_CFG_ADDR, gcfg);
        rd(BIAS_RATE_ADDR, {3'h0, brate, 21'h0});
        expDiv = int'(tcfg.pixelClockDivider);
        pendDiv = expDiv;
        {lineSkip, frameSkip, biasSkip} = 3'b111;
        tcfg.videoEnable = 1'b1;
        wr(TIMING_CFG_ADDR, tcfg);
        live = 1;
        @(negedge ref_clk);
        check(fifoClear, 1'b0);
        repeat (300) @(posedge ref_clk);
        if (newDiv != 0) begin
            // Write well clear of a frame end so the switch frame is known
            while (!frameStb) @(posedge ref_clk);
            tcfg.pixelClockDivider = 10'(newDiv);
            pendDiv = newDiv;
            wr(TIMING_CFG_ADDR, tcfg);
        end
        repeat (500) @(posedge ref_clk);
        live = 0;
        tcfg.videoEnable = 1'b0;
        wr(TIMING_CFG_ADDR, tcfg);
        @(negedge ref_clk);
        check(fifoClear, 1'b1);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check(panelPins.linePulse, tcfg.linePulsePolarity);
        dataQ.delete();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        rdSeen <= regRdStb;
        if (newByte) videoByte <= 8'($urandom);
        newByte = 0;
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    always @(negedge ref_clk) begin
        if (videoByteTaken === 1'b1) begin
            dataQ.push_back(fmt_byte(videoByte));
            newByte = 1;
        end
        if (rdSeen) check(regRdData, rdQ.pop_front());
        if (sampleStb && live) check(sampleByte, dataQ.size() ? dataQ.pop_front() : 8'h5A);
        if (lineStb && live && !lineSkip) begin
            check(pulseW, 4 * (tcfg.linePulseWidth + 1));
            check(delayC, 4 * (tcfg.lineToClockDelay + 1) + expDiv);
            check(periodC, 2 * expDiv);
            check(pixCnt, gcfg.horizontalSize + 1);
            check(lineC, 4 * (tcfg.linePulseWidth + tcfg.lineToClockDelay + 2)
                + (gcfg.horizontalSize + 1) * 2 * expDiv + gcfg.lineBlankA);
        end
        if (lineStb && live) lineSkip = 0;
        if (frameStb) begin
            if (live && !frameSkip) check(frameLines, gcfg.verticalSize + 1);
            frameSkip = frameSkip & ~live;
            expDiv = pendDiv;
        end
        if (biasStb && live) begin
            if (!biasSkip) check(biasLines, tcfg.biasMode ? brate + 1 : gcfg.verticalSize + 1);
            biasSkip = 0;
        end
    end

    initial begin
        reset_n = 1'b0;
        regAddr = '0;
        regWrData = '0;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        videoByte = 8'h00;
        void'($urandom(32'h99d632f7));
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(TIMING_CFG_ADDR, TIMING_CFG_RESET);
        rd(GEOMETRY_CFG_ADDR, GEOMETRY_CFG_RESET);
        rd(BIAS_RATE_ADDR, {3'h0, BIAS_RATE_RESET, 21'h0});
        wr(32'h01F00008, 32'hFFFFFFFF);
        rd(32'h01F00008, 32'h00000000);
        for (int f = 0; f < 4; f++) begin
            run_cfg(f, 0);
        end
        run_cfg(2, int'(tcfg.pixelClockDivider) % 3 + 1);
        repeat (4) @(posedge ref_clk);
        tally_and_finish();
    end
endmodule
